//--- bench/ext_interrupt0_wakeup_bench.sv
// self-checking bench for the external interrupt 0 request and wakeup block
`timescale 1ns/100ps
`default_nettype none
module ext_interrupt0_wakeup_bench;
  // ****************************************************************
  // design hookup and model state
  // ****************************************************************
  logic mclk_in;
  logic nrst_in;
  logic [eiw_pkg::ADDR_W-1:0] avs_address_in;
  logic avs_read_in;
  logic avs_write_in;
  logic [eiw_pkg::DATA_W-1:0] avs_writedata_in;
  logic [eiw_pkg::BE_W-1:0] avs_byteenable_in;
  logic [eiw_pkg::DATA_W-1:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic ext_irq0_pin_in;
  logic irq_ack_in;
  logic ext0_irq_out, skip_out, backup_out, irq_out;
  logic [31:0] rd_q;
  int bad_count, n_tests, p, lo;
  int cycles = 0;
  // behavioural model of the register view
  int m_ctrl, m_ien, m_wake, m_flag, m_backup, m_skip, m_armed, m_evt, m_mask;
  logic [7:0] addrs [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};

  // free-running 100 MHz clock
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  eiw_core i_dut (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .ext_irq0_pin_in(ext_irq0_pin_in),
    .irq_ack_in(irq_ack_in),
    .ext0_irq_out(ext0_irq_out),
    .skip_out(skip_out),
    .backup_out(backup_out),
    .irq_out(irq_out)
  );

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      wrap_up();
    end
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  // verdict and end of run
  task wrap_up;
    if (bad_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  // one comparison, four-state exact
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one bus access; idle edge first so a strobe is never dropped and raised at once
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge mclk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_byteenable_in <= be;
    avs_write_in <= wr;
    avs_read_in <= ~wr;
    do begin
      @(posedge mclk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 64);
    rd_q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    if (n >= 64) begin
      bad_count++;
      wrap_up();
    end
  endtask : bus

  // full-byte write
  task wr(input logic [7:0] a, input int d);
    bus(1'b1, a, d, 4'hf);
  endtask : wr

  // instruction issue
  task cmd(input int v);
    wr(eiw_pkg::CMD_OFS, v);
  endtask : cmd

  // expected read value from the model
  function automatic logic [31:0] mread(input logic [7:0] a);
    case (a)
      eiw_pkg::CTRL_OFS: mread = 32'(m_ctrl);
      eiw_pkg::IEN_OFS: mread = 32'(m_ien);
      eiw_pkg::WAKE_OFS: mread = 32'(m_wake);
      eiw_pkg::STAT_OFS: mread = 32'(m_flag + 2 * m_backup + 4 * m_skip + 8 * m_armed);
      eiw_pkg::EVT_OFS: mread = 32'(m_evt);
      eiw_pkg::MASK_OFS: mread = 32'(m_mask);
      default: mread = 32'h0000_0000;
    endcase
  endfunction : mread

  // read and compare against the model
  task rchk(input logic [7:0] a);
    bus(1'b0, a, 32'h0000_0000, 4'hf);
    check($sformatf("read %h", a), rd_q, mread(a));
  endtask : rchk

  // pin change, then time for the two-flop sync and flag edge
  task pin_to(input int v);
    @(posedge mclk_in);
    ext_irq0_pin_in <= v[0];
    repeat (5) @(posedge mclk_in);
  endtask : pin_to

  // control write with settling time
  task ctrl(input int v);
    wr(eiw_pkg::CTRL_OFS, v);
    m_ctrl = v;
    repeat (2) @(posedge mclk_in);
  endtask : ctrl

  // skip instruction; pulse stands exactly one cycle after the taking edge, then a no-op
  task skip_chk;
    cmd(32'(eiw_pkg::CMD_SKIP));
    m_skip = (m_flag == 1 && m_ien == 0);
    if (m_ien == 0) m_flag = 0;
    @(posedge mclk_in);
    check("skip pulse", 32'(skip_out), m_skip);
    @(posedge mclk_in);
    check("skip pulse end", 32'(skip_out), 0);
    cmd(0);
  endtask : skip_chk

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    nrst_in = 1'b0;
    avs_address_in = '0;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_writedata_in = '0;
    avs_byteenable_in = '0;
    ext_irq0_pin_in = 1'b0;
    irq_ack_in = 1'b0;
    {bad_count, n_tests, m_ctrl, m_ien, m_wake, m_flag, m_backup} = '0;
    {m_skip, m_armed, m_evt, m_mask} = '0;
    lo = $urandom(32'hbb60) % 4;
    p = $urandom % 2;
    repeat (8) @(posedge mclk_in);
    nrst_in <= 1'b1;
    for (int i = 0; i < 8; i++) rchk(addrs[i]);
    // pin activity is invisible while the input is off
    ctrl(4 + lo);
    pin_to(1);
    pin_to(0);
    pin_to(1);
    rchk(eiw_pkg::STAT_OFS);
    // turning the input on at a valid level raises the request
    ctrl(12 + lo);
    m_flag = 1;
    m_evt = 1;
    rchk(eiw_pkg::STAT_OFS);
    check("ext0 irq", 32'(ext0_irq_out), 0);
    wr(eiw_pkg::MASK_OFS, 1);
    m_mask = 1;
    repeat (2) @(posedge mclk_in);
    check("irq", 32'(irq_out), 1);
    cmd(0);
    skip_chk();
    rchk(eiw_pkg::STAT_OFS);
    // both waveforms: select change and pin edge each set the flag
    for (int i = 0; i < 2; i++) begin
      p = 1 - p;
      pin_to(p);
      wr(eiw_pkg::IEN_OFS, 0);
      ctrl(8 + 4 * (1 - p) + lo);
      rchk(eiw_pkg::STAT_OFS);
      ctrl(8 + 4 * p + lo);
      m_flag = 1;
      rchk(eiw_pkg::STAT_OFS);
      cmd(0);
      skip_chk();
      pin_to(1 - p);
      pin_to(p);
      m_flag = 1;
      rchk(eiw_pkg::STAT_OFS);
      skip_chk();
    end
    // enable gates the request line; skip is inert while enabled
    wr(eiw_pkg::IEN_OFS, 1);
    m_ien = 1;
    pin_to(1 - p);
    pin_to(p);
    m_flag = 1;
    check("ext0 irq", 32'(ext0_irq_out), 1);
    skip_chk();
    rchk(eiw_pkg::STAT_OFS);
    @(posedge mclk_in);
    irq_ack_in <= 1'b1;
    @(posedge mclk_in);
    irq_ack_in <= 1'b0;
    repeat (3) @(posedge mclk_in);
    m_flag = 0;
    check("ext0 irq", 32'(ext0_irq_out), 0);
    wr(eiw_pkg::IEN_OFS, 0);
    m_ien = 0;
    // event masking and write-one clearing
    wr(eiw_pkg::MASK_OFS, 0);
    m_mask = 0;
    repeat (2) @(posedge mclk_in);
    check("irq", 32'(irq_out), 0);
    wr(eiw_pkg::MASK_OFS, 7);
    m_mask = 7;
    repeat (2) @(posedge mclk_in);
    check("irq", 32'(irq_out), 1);
    wr(eiw_pkg::EVT_OFS, 1);
    m_evt = 0;
    repeat (2) @(posedge mclk_in);
    check("irq", 32'(irq_out), 0);
    // power-off alone, and with an instruction after the arm
    cmd(32'(eiw_pkg::CMD_POF));
    repeat (3) @(posedge mclk_in);
    m_evt = 4;
    check("backup", 32'(backup_out), 0);
    rchk(eiw_pkg::EVT_OFS);
    cmd(32'(eiw_pkg::CMD_ARM));
    m_armed = 1;
    rchk(eiw_pkg::STAT_OFS);
    cmd(0);
    m_armed = 0;
    cmd(32'(eiw_pkg::CMD_POF));
    repeat (3) @(posedge mclk_in);
    check("backup", 32'(backup_out), 0);
    // a byte-disabled write is no instruction, so the pair still counts
    pin_to(1 - p);
    wr(eiw_pkg::WAKE_OFS, 1); // input stays enabled, though wakeup does not depend on it
    m_wake = 1;
    cmd(32'(eiw_pkg::CMD_ARM));
    bus(1'b1, eiw_pkg::CMD_OFS, 32'h0000_0000, 4'h0);
    cmd(32'(eiw_pkg::CMD_POF));
    repeat (2) @(posedge mclk_in);
    m_backup = 1;
    check("backup", 32'(backup_out), 1);
    rchk(eiw_pkg::STAT_OFS);
    // valid level with wakeup enabled leaves back-up
    pin_to(p);
    m_backup = 0;
    m_flag = 1;
    m_evt = 7;
    check("backup", 32'(backup_out), 0);
    rchk(eiw_pkg::EVT_OFS);
    rchk(eiw_pkg::STAT_OFS);
    // every register against the model once more, control, enable and mask included
    for (int i = 0; i < 8; i++) rchk(addrs[i]);
    wrap_up();
  end
endmodule : ext_interrupt0_wakeup_bench
`default_nettype wire

//--- rtl/eiw_core.sv
// external interrupt 0 request, skip test, wakeup and back-up control with bus slave
`timescale 1ns/100ps
`default_nettype none
module eiw_core (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic [eiw_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [eiw_pkg::DATA_W-1:0] avs_writedata_in,
  input wire logic [eiw_pkg::BE_W-1:0] avs_byteenable_in,
  output logic [eiw_pkg::DATA_W-1:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic ext_irq0_pin_in,
  input wire logic irq_ack_in,
  output logic ext0_irq_out,
  output logic skip_out,
  output logic backup_out,
  output logic irq_out
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  eiw_pin_if pif ();

  logic wait_reg;
  logic [eiw_pkg::DATA_W-1:0] rdata_reg;
  logic [eiw_pkg::DATA_W-1:0] rdata_next;
  logic [eiw_pkg::CTRL_W-1:0] ext0_control_reg;
  logic irq_enable_reg;
  logic wakeup_reg;
  logic ext0_request_flag_reg;
  logic ext0_request_flag_next;
  logic skip_res_reg;
  logic skip_reg;
  logic ext0_irq_reg;
  logic irq_reg;
  logic [eiw_pkg::EVT_W-1:0] evt_reg;
  logic [eiw_pkg::EVT_W-1:0] evt_next;
  logic [eiw_pkg::EVT_W-1:0] evt_set;
  logic [eiw_pkg::EVT_W-1:0] mask_reg;
  logic req;
  logic take;
  logic wr;
  logic wr_cmd;
  logic [eiw_pkg::CMD_W-1:0] cmd;
  logic skip_cmd;
  logic arm_cmd;
  logic pof_cmd;
  logic skip_clr;
  logic seq_armed;
  logic seq_backup;
  logic seq_refused;
  logic seq_woke;

  // ****************************************************************
  // address decode
  // ****************************************************************
  // one decoder shared by write strobes and the read mux
  function automatic logic hit(
    input logic [eiw_pkg::ADDR_W-1:0] addr,
    input logic [eiw_pkg::ADDR_W-1:0] ofs
  );
    return addr == ofs;
  endfunction : hit

  // ****************************************************************
  // avalon slave handshake
  // ****************************************************************
  // every access waits one cycle, so read data can come from a flop
  assign req = avs_read_in | avs_write_in;
  assign take = req & ~wait_reg;
  // writes only count when the low byte lane is enabled
  assign wr = take & avs_write_in & avs_byteenable_in[0];
  assign wr_cmd = wr & hit(avs_address_in, eiw_pkg::CMD_OFS);
  assign cmd = avs_writedata_in[eiw_pkg::CMD_W-1:0];

  // waitrequest drops for exactly the accepting cycle
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      wait_reg <= 1'h1;
    end else if (req && wait_reg) begin
      wait_reg <= 1'h0;
    end else begin
      wait_reg <= 1'h1;
    end
  end

  // read mux, unmapped offsets read as zero
  always_comb begin
    rdata_next = eiw_pkg::RDATA_RST;
    if (hit(avs_address_in, eiw_pkg::CTRL_OFS)) begin
      rdata_next[eiw_pkg::CTRL_W-1:0] = ext0_control_reg;
    end else if (hit(avs_address_in, eiw_pkg::IEN_OFS)) begin
      rdata_next[eiw_pkg::IEN_EXT0_BIT] = irq_enable_reg;
    end else if (hit(avs_address_in, eiw_pkg::WAKE_OFS)) begin
      rdata_next[eiw_pkg::WAKE_EXT0_BIT] = wakeup_reg;
    end else if (hit(avs_address_in, eiw_pkg::STAT_OFS)) begin
      rdata_next[eiw_pkg::STAT_FLAG_BIT] = ext0_request_flag_reg;
      rdata_next[eiw_pkg::STAT_BACKUP_BIT] = seq_backup;
      rdata_next[eiw_pkg::STAT_SKIP_BIT] = skip_res_reg;
      rdata_next[eiw_pkg::STAT_ARMED_BIT] = seq_armed;
    end else if (hit(avs_address_in, eiw_pkg::EVT_OFS)) begin
      rdata_next[eiw_pkg::EVT_W-1:0] = evt_reg;
    end else if (hit(avs_address_in, eiw_pkg::MASK_OFS)) begin
      rdata_next[eiw_pkg::EVT_W-1:0] = mask_reg;
    end
  end

  // read data latched as waitrequest falls, stands at the taking edge
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      rdata_reg <= eiw_pkg::RDATA_RST;
    end else if (avs_read_in && wait_reg) begin
      rdata_reg <= rdata_next;
    end
  end

  // ****************************************************************
  // control registers
  // ****************************************************************
  // external 0 control: input enable and valid waveform select
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      ext0_control_reg <= eiw_pkg::CTRL_RST;
    end else if (wr && hit(avs_address_in, eiw_pkg::CTRL_OFS)) begin
      ext0_control_reg <= avs_writedata_in[eiw_pkg::CTRL_W-1:0];
    end
  end

  // interrupt enable; software clears it before touching control bits
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      irq_enable_reg <= eiw_pkg::IEN_RST;
    end else if (wr && hit(avs_address_in, eiw_pkg::IEN_OFS)) begin
      irq_enable_reg <= avs_writedata_in[eiw_pkg::IEN_EXT0_BIT];
    end
  end

  // key-on wakeup enable, not gated by the input enable on purpose
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      wakeup_reg <= eiw_pkg::WAKE_RST;
    end else if (wr && hit(avs_address_in, eiw_pkg::WAKE_OFS)) begin
      wakeup_reg <= avs_writedata_in[eiw_pkg::WAKE_EXT0_BIT];
    end
  end

  // ****************************************************************
  // pin detector
  // ****************************************************************
  assign pif.input_en = ext0_control_reg[eiw_pkg::CTRL_IN_EN_BIT];
  assign pif.wave_sel = ext0_control_reg[eiw_pkg::CTRL_SEL_BIT];

  eiw_pin_detect u_detect (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .ext_irq0_pin_in(ext_irq0_pin_in),
    .pin_if(pif.det)
  );

  // ****************************************************************
  // instruction decode
  // ****************************************************************
  // a command word with more than one bit set counts as a plain instruction
  assign skip_cmd = wr_cmd & (cmd == eiw_pkg::CMD_SKIP);
  assign arm_cmd = wr_cmd & (cmd == eiw_pkg::CMD_ARM);
  assign pof_cmd = wr_cmd & (cmd == eiw_pkg::CMD_POF);

  // ****************************************************************
  // request flag and skip test
  // ****************************************************************
  // the skip only clears while the interrupt is disabled
  assign skip_clr = (skip_cmd & ~irq_enable_reg) | irq_ack_in;

  // a new edge in the clearing cycle is kept: set beats clear
  always_comb begin
    ext0_request_flag_next = ext0_request_flag_reg & ~skip_clr;
    if (pif.active_rise) begin
      ext0_request_flag_next = 1'h1;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      ext0_request_flag_reg <= 1'h0;
    end else begin
      ext0_request_flag_reg <= ext0_request_flag_next;
    end
  end

  // skip result: pulse on skip_out plus a readable copy
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      skip_reg <= 1'h0;
      skip_res_reg <= 1'h0;
    end else begin
      skip_reg <= skip_cmd & ~irq_enable_reg & ext0_request_flag_reg;
      if (skip_cmd) begin
        skip_res_reg <= ~irq_enable_reg & ext0_request_flag_reg;
      end
    end
  end

  // core interrupt request, held back while the enable is clear
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      ext0_irq_reg <= 1'h0;
    end else begin
      ext0_irq_reg <= ext0_request_flag_reg & irq_enable_reg;
    end
  end

  // ****************************************************************
  // power-off sequencing
  // ****************************************************************
  // every accepted write with the low byte lane enabled counts as one executed instruction
  eiw_pwr_seq u_seq (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .instr_in(wr),
    .arm_in(arm_cmd),
    .pof_in(pof_cmd),
    .wake_in(wakeup_reg & pif.valid_level),
    .backup_out(seq_backup),
    .armed_out(seq_armed),
    .refused_out(seq_refused),
    .woke_out(seq_woke)
  );

  // ****************************************************************
  // sticky events and interrupt line
  // ****************************************************************
  assign evt_set = {seq_refused, seq_woke, pif.active_rise};

  // write one to clear, a same-cycle event keeps its bit
  always_comb begin
    evt_next = evt_reg;
    if (wr && hit(avs_address_in, eiw_pkg::EVT_OFS)) begin
      evt_next = evt_reg & ~avs_writedata_in[eiw_pkg::EVT_W-1:0];
    end
    evt_next = evt_next | evt_set;
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      evt_reg <= eiw_pkg::EVT_RST;
    end else begin
      evt_reg <= evt_next;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      mask_reg <= eiw_pkg::MASK_RST;
    end else if (wr && hit(avs_address_in, eiw_pkg::MASK_OFS)) begin
      mask_reg <= avs_writedata_in[eiw_pkg::EVT_W-1:0];
    end
  end

  // registered so the output never glitches on decode
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      irq_reg <= 1'h0;
    end else begin
      irq_reg <= |(evt_reg & mask_reg);
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign avs_readdata_out = rdata_reg;
  assign avs_waitrequest_out = wait_reg;
  assign ext0_irq_out = ext0_irq_reg;
  assign skip_out = skip_reg;
  assign backup_out = seq_backup;
  assign irq_out = irq_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  flag_set_a: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    pif.active_rise |=> ext0_request_flag_reg
  ) else $error("request flag not set after valid waveform");

  pin_ignored_a: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    !ext0_control_reg[eiw_pkg::CTRL_IN_EN_BIT] |-> !pif.active_rise
  ) else $error("pin seen while input disabled");

  ctrl_edge_a: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    ($rose(ext0_control_reg[eiw_pkg::CTRL_IN_EN_BIT]) && pif.valid_level)
      |=> ext0_request_flag_reg
  ) else $error("enabling input at valid level did not set flag");

  wave_edge_a: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    ($changed(ext0_control_reg[eiw_pkg::CTRL_SEL_BIT])
      && $stable(ext0_control_reg[eiw_pkg::CTRL_IN_EN_BIT])
      && ext0_control_reg[eiw_pkg::CTRL_IN_EN_BIT]
      && pif.valid_level && $stable(pif.valid_level) == 1'h0)
      |=> ext0_request_flag_reg
  ) else $error("waveform change at valid level did not set flag");

  skip_clear_a: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    (skip_cmd && !irq_enable_reg && !pif.active_rise)
      |=> !ext0_request_flag_reg && (skip_res_reg == $past(ext0_request_flag_reg))
  ) else $error("skip did not test and clear the flag");

  skip_enabled_a: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    (skip_cmd && irq_enable_reg && ext0_request_flag_reg && !irq_ack_in)
      |=> ext0_request_flag_reg && !skip_out
  ) else $error("skip acted while interrupt enabled");

  irq_gate_a: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    (ext0_request_flag_reg && irq_enable_reg) [*2] |-> ext0_irq_out
  ) else $error("enabled request not raised");

  irq_block_a: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    !irq_enable_reg |=> !ext0_irq_out
  ) else $error("request raised while disabled");

  backup_entry_a: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    (pof_cmd && seq_armed) |=> backup_out
  ) else $error("armed power-off did not enter back-up");

  pof_alone_a: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    (pof_cmd && !seq_armed && !backup_out) |=> !backup_out ##1 evt_reg[eiw_pkg::EVT_REFUSE_BIT]
  ) else $error("lone power-off entered back-up");

  wake_exit_a: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    (backup_out && wakeup_reg && pif.valid_level) |=> !backup_out
  ) else $error("wakeup level did not end back-up");

  bus_answer_a: assert property (
    @(posedge mclk_in) disable iff (!nrst_in)
    (req && avs_waitrequest_out) |=> !avs_waitrequest_out
  ) else $error("bus access not answered in one cycle");

endmodule : eiw_core
`default_nettype wire

//--- rtl/eiw_pin_detect.sv
// synchroniser and valid-waveform detector for the external interrupt 0 pin
`timescale 1ns/100ps
`default_nettype none
module eiw_pin_detect (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic ext_irq0_pin_in,
  eiw_pin_if.det pin_if
);

  logic sync1_reg;
  logic sync2_reg;
  logic active_reg;
  logic active_now;

  // two-stage synchroniser, first stage read by nothing else
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      sync1_reg <= 1'h0;
      sync2_reg <= 1'h0;
    end else begin
      sync1_reg <= ext_irq0_pin_in;
      sync2_reg <= sync1_reg;
    end
  end

  // select 1 takes high level / rising edge, 0 low level / falling edge
  assign pin_if.valid_level = pin_if.wave_sel ? sync2_reg : ~sync2_reg;
  // a disabled input never looks active
  assign active_now = pin_if.input_en & pin_if.valid_level;

  // previous gated level, so that control writes also make edges
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      active_reg <= 1'h0;
    end else begin
      active_reg <= active_now;
    end
  end

  // a change of either control bit can turn the gated level on
  assign pin_if.active_rise = active_now & ~active_reg;

endmodule : eiw_pin_detect
`default_nettype wire

//--- rtl/eiw_pin_if.sv
// interface between the pin detector and the request core
`timescale 1ns/100ps
`default_nettype none
interface eiw_pin_if;
  logic input_en;
  logic wave_sel;
  logic valid_level;
  logic active_rise;
  modport det (
    input input_en,
    input wave_sel,
    output valid_level,
    output active_rise
  );
  modport core (
    output input_en,
    output wave_sel,
    input valid_level,
    input active_rise
  );
endinterface : eiw_pin_if
`default_nettype wire

//--- rtl/eiw_pkg.sv
// constants, state type and register map of the external interrupt 0 request and wakeup block
//
// Overview of operation
// - input-enable change may set request flag
// - waveform-select change may set request flag
// - waveform bit picks the valid pin waveform
// - skip instruction tests, skips, clears flag while interrupt disabled
// - input disabled means pin is ignored, except by wakeup
// - arm then power-off enters back-up
// - lone power-off never enters back-up
package eiw_pkg;

  // ****************************************************************
  // bus shape
  // ****************************************************************
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int BE_W = 4;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] IEN_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] WAKE_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] CMD_OFS = 8'h0C;
  localparam logic [ADDR_W-1:0] STAT_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] EVT_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] MASK_OFS = 8'h18;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CTRL_W = 4;
  localparam int CTRL_IN_EN_BIT = 3;
  localparam int CTRL_SEL_BIT = 2;
  localparam int IEN_EXT0_BIT = 0;
  localparam int WAKE_EXT0_BIT = 0;
  localparam int CMD_W = 3;
  localparam logic [CMD_W-1:0] CMD_SKIP = 3'h1;
  localparam logic [CMD_W-1:0] CMD_ARM = 3'h2;
  localparam logic [CMD_W-1:0] CMD_POF = 3'h4;
  localparam int STAT_FLAG_BIT = 0;
  localparam int STAT_BACKUP_BIT = 1;
  localparam int STAT_SKIP_BIT = 2;
  localparam int STAT_ARMED_BIT = 3;
  localparam int EVT_W = 3;
  localparam int EVT_REQ_BIT = 0;
  localparam int EVT_WAKE_BIT = 1;
  localparam int EVT_REFUSE_BIT = 2;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
  localparam logic IEN_RST = 1'h0;
  localparam logic WAKE_RST = 1'h0;
  localparam logic [EVT_W-1:0] EVT_RST = 3'h0;
  localparam logic [EVT_W-1:0] MASK_RST = 3'h0;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

  // power sequencing states, gray along run, armed, back-up
  typedef enum logic [1:0] {
    PWR_RUN = 2'h0,
    PWR_ARMED = 2'h1,
    PWR_BACKUP = 2'h3
  } eiw_pwr_t;

endpackage : eiw_pkg

//--- rtl/eiw_pwr_seq.sv
// arm and power-off sequencer holding the ram back-up state
`timescale 1ns/100ps
`default_nettype none
module eiw_pwr_seq (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic instr_in,
  input wire logic arm_in,
  input wire logic pof_in,
  input wire logic wake_in,
  output logic backup_out,
  output logic armed_out,
  output logic refused_out,
  output logic woke_out
);

  eiw_pkg::eiw_pwr_t state_reg;
  eiw_pkg::eiw_pwr_t state_next;

  // arming lasts exactly one instruction
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      eiw_pkg::PWR_RUN: begin
        if (arm_in) begin
          state_next = eiw_pkg::PWR_ARMED;
        end
      end
      eiw_pkg::PWR_ARMED: begin
        if (pof_in) begin
          state_next = eiw_pkg::PWR_BACKUP;
        end else if (!arm_in && instr_in) begin
          state_next = eiw_pkg::PWR_RUN;
        end
      end
      eiw_pkg::PWR_BACKUP: begin
        if (wake_in) begin
          state_next = eiw_pkg::PWR_RUN;
        end
      end
      default: begin
        state_next = eiw_pkg::PWR_RUN;
      end
    endcase
  end

  // state and one-cycle event pulses
  always_ff @(posedge mclk_in) begin
    if (!nrst_in) begin
      state_reg <= eiw_pkg::PWR_RUN;
      refused_out <= 1'h0;
      woke_out <= 1'h0;
    end else begin
      state_reg <= state_next;
      refused_out <= pof_in && (state_reg == eiw_pkg::PWR_RUN);
      woke_out <= wake_in && (state_reg == eiw_pkg::PWR_BACKUP);
    end
  end

  assign backup_out = state_reg[1];
  assign armed_out = (state_reg == eiw_pkg::PWR_ARMED);

endmodule : eiw_pwr_seq
`default_nettype wire
